//--- src/sirq_bank.sv
// One status source: edge one-shots, sticky flags and masked requests.
`include "sirq_regs.svh"
module sirq_bank #(
  parameter int W = 16
) (
  input wire logic sys_clk, // Clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes state when low.
  sirq_src_if.bank s // Source signals.
);
  logic [W-1:0] cond_q;
  logic [W-1:0] rise;
  assign rise = s.cond & ~cond_q;

  // Previous condition for one-shot detection.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_q <= '0;
    end else if (clk_en) begin
      cond_q <= s.cond;
    end
  end

  // One-shot per bit, registered.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s.event_q <= '0;
    end else if (clk_en) begin
      s.event_q <= rise;
    end
  end

  // A read clears sticky bits unless the condition persists; a new event wins.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s.sticky <= '0;
    end else if (clk_en) begin
      if (s.read_clr) begin
        s.sticky <= s.cond | rise;
      end else begin
        s.sticky <= s.sticky | s.cond;
      end
    end
  end

  // Level request is the OR of unmasked sticky bits, edge request of unmasked one-shots.
  assign s.req_level = |(s.sticky & ~s.mask);
  assign s.req_edge = |(s.event_q & ~s.mask);

  a_sticky_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && s.read_clr && (s.cond != '0)) |=> ((s.sticky & $past(s.cond)) == $past(s.cond)))
    else $error("Sticky bit cleared while condition present.");
  a_one_shot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && (rise != '0)) |=> (s.event_q == $past(rise)))
    else $error("Rising condition did not make a one-shot.");
endmodule : sirq_bank

//--- src/sirq_pkg.sv
// Types shared by the interrupt unit modules.
package sirq_pkg;
  typedef enum logic [1:0] {
    SIRQ_SRC_GEN = 2'b00,
    SIRQ_SRC_ALM = 2'b01
  } sirq_src_t;
  typedef enum logic [0:0] {
    SIRQ_P_IDLE = 1'b0,
    SIRQ_P_FIRE = 1'b1
  } sirq_pulse_state_t;
endpackage : sirq_pkg

//--- src/sirq_regs.svh
// Register offsets, field positions, reset values and timing counts of the interrupt unit.
`ifndef SIRQ_REGS_SVH
`define SIRQ_REGS_SVH
`define SIRQ_ADDR_W 4
`define SIRQ_OFF_GEN_FLAGS 4'h0
`define SIRQ_OFF_ALM_FLAGS 4'h1
`define SIRQ_OFF_GEN_MASK 4'h2
`define SIRQ_OFF_ALM_MASK 4'h3
`define SIRQ_OFF_CONFIG 4'h4
`define SIRQ_OFF_IRQ_STAT 4'h5
`define SIRQ_OFF_IRQ_CLR 4'h6
`define SIRQ_OFF_IRQ_EN 4'h7
`define SIRQ_OFF_LIVE 4'h8
`define SIRQ_CFG_LVL_BIT 0
`define SIRQ_CFG_POL_BIT 1
`define SIRQ_CFG_PIN_EN_BIT 2
`define SIRQ_CFG_SPI_MODE_BIT 3
`define SIRQ_CFG_RESET 4'h3
`define SIRQ_MASK_RESET 16'hFFFF
`define SIRQ_EV_GEN_BIT 0
`define SIRQ_EV_ALM_BIT 1
`define SIRQ_EV_OUT_BIT 2
`define SIRQ_CLK_PERIOD_NS 100
`define SIRQ_PULSE_NS 100
`define SIRQ_PULSE_CYC ((`SIRQ_PULSE_NS + `SIRQ_CLK_PERIOD_NS - 1) / `SIRQ_CLK_PERIOD_NS)
`endif

//--- src/sirq_src_if.sv
// Signals between the top and one status source bank.
interface sirq_src_if #(parameter int W = 16);
  logic [W-1:0] cond;
  logic [W-1:0] mask;
  logic read_clr;
  logic [W-1:0] sticky;
  logic [W-1:0] event_q;
  logic req_level;
  logic req_edge;
  modport bank (input cond, input mask, input read_clr, output sticky, output event_q,
    output req_level, output req_edge);
  modport top (output cond, output mask, output read_clr, input sticky, input event_q,
    input req_level, input req_edge);
endinterface : sirq_src_if

//--- src/sirq_top.sv
// Status interrupt request unit: two sources, masks, sticky flags, pin drive.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`include "sirq_regs.svh"
module sirq_top #(
  parameter int W = 16
) (
  input wire logic sys_clk, // 10 MHz clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state when low.
  input wire logic [W-1:0] gen_cond, // General status conditions.
  input wire logic [W-1:0] alm_cond, // Alarm status conditions.
  input wire logic uart_tx, // Transmit data from the serial block.
  input wire logic [`SIRQ_ADDR_W-1:0] addr, // Register address.
  input wire logic [W-1:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  output logic [W-1:0] rdata, // Read data, one cycle after rd.
  output logic irq_pin, // Interrupt pin, polarity applied.
  output logic alarm_pin_n, // Alarm pin, low while an alarm is pending.
  output logic serial_transmit_pin, // Transmit pin, or interrupt when routed.
  output logic unit_irq // Level interrupt of the event status register.
);
  logic [W-1:0] gen_mask;
  logic [W-1:0] alm_mask;
  logic [3:0] cfg;
  logic [2:0] ev_stat;
  logic [2:0] ev_en;
  logic irq_active;
  logic next_irq_active;
  logic level_sensitive_select;
  logic interrupt_polarity;
  logic general_interrupt_request;
  logic alarm_request;
  logic pin_en;
  logic spi_mode;
  logic [2:0] ev_set;
  logic irq_out;
  sirq_pkg::sirq_pulse_state_t pstate;

  sirq_src_if #(.W(W)) gen_if ();
  sirq_src_if #(.W(W)) alm_if ();

  function automatic logic hit(input logic [`SIRQ_ADDR_W-1:0] a,
      input logic [`SIRQ_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic pin_level(input logic act, input logic pol);
    pin_level = act ~^ pol;
  endfunction : pin_level

  assign level_sensitive_select = cfg[`SIRQ_CFG_LVL_BIT];
  assign interrupt_polarity = cfg[`SIRQ_CFG_POL_BIT];
  assign pin_en = cfg[`SIRQ_CFG_PIN_EN_BIT];
  assign spi_mode = cfg[`SIRQ_CFG_SPI_MODE_BIT];

  assign gen_if.cond = gen_cond;
  assign gen_if.mask = gen_mask;
  assign gen_if.read_clr = rd && hit(addr, `SIRQ_OFF_GEN_FLAGS);
  assign alm_if.cond = alm_cond;
  assign alm_if.mask = alm_mask;
  assign alm_if.read_clr = rd && hit(addr, `SIRQ_OFF_ALM_FLAGS);

  sirq_bank #(.W(W)) u_gen (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .s(gen_if.bank)
  );
  sirq_bank #(.W(W)) u_alm (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .s(alm_if.bank)
  );

  assign general_interrupt_request = level_sensitive_select ? gen_if.req_level
                                                            : gen_if.req_edge;
  assign alarm_request = level_sensitive_select ? alm_if.req_level : alm_if.req_edge;

  // Level mode follows the masked sticky flags; edge mode is a one-cycle pulse.
  always_comb begin
    next_irq_active = general_interrupt_request | alarm_request;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_active <= 1'b0;
      pstate <= sirq_pkg::SIRQ_P_IDLE;
    end else if (clk_en) begin
      irq_active <= next_irq_active;
      case (pstate)
        sirq_pkg::SIRQ_P_IDLE: begin
          if (!level_sensitive_select && next_irq_active) begin
            pstate <= sirq_pkg::SIRQ_P_FIRE;
          end
        end
        sirq_pkg::SIRQ_P_FIRE: begin
          if (level_sensitive_select || !next_irq_active) begin
            pstate <= sirq_pkg::SIRQ_P_IDLE;
          end
        end
        default: begin
          pstate <= sirq_pkg::SIRQ_P_IDLE;
        end
      endcase
    end
  end

  // Mask and configuration registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_mask <= `SIRQ_MASK_RESET;
    end else if (clk_en && wr && hit(addr, `SIRQ_OFF_GEN_MASK)) begin
      gen_mask <= wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alm_mask <= `SIRQ_MASK_RESET;
    end else if (clk_en && wr && hit(addr, `SIRQ_OFF_ALM_MASK)) begin
      alm_mask <= wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= `SIRQ_CFG_RESET;
    end else if (clk_en && wr && hit(addr, `SIRQ_OFF_CONFIG)) begin
      cfg <= wdata[3:0];
    end
  end

  // Unit event status: general request, alarm request, registered combined request.
  assign ev_set = {irq_active, alarm_request, general_interrupt_request};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_stat <= 3'h0;
    end else if (clk_en) begin
      if (wr && hit(addr, `SIRQ_OFF_IRQ_CLR)) begin
        ev_stat <= (ev_stat & ~wdata[2:0]) | ev_set;
      end else begin
        ev_stat <= ev_stat | ev_set;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_en <= 3'h0;
    end else if (clk_en && wr && hit(addr, `SIRQ_OFF_IRQ_EN)) begin
      ev_en <= wdata[2:0];
    end
  end

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (clk_en) begin
      rdata <= '0;
      if (rd) begin
        case (addr)
          `SIRQ_OFF_GEN_FLAGS: rdata <= gen_if.sticky;
          `SIRQ_OFF_ALM_FLAGS: rdata <= alm_if.sticky;
          `SIRQ_OFF_GEN_MASK: rdata <= gen_mask;
          `SIRQ_OFF_ALM_MASK: rdata <= alm_mask;
          `SIRQ_OFF_CONFIG: rdata <= {{(W-4){1'b0}}, cfg};
          `SIRQ_OFF_IRQ_STAT: rdata <= {{(W-3){1'b0}}, ev_stat};
          `SIRQ_OFF_IRQ_EN: rdata <= {{(W-3){1'b0}}, ev_en};
          `SIRQ_OFF_LIVE: rdata <= {{(W-2){1'b0}}, alarm_request, general_interrupt_request};
          default: rdata <= '0;
        endcase
      end
    end
  end

  // Pins: interrupt gated by pin enable, polarity applied; transmit pin carries it in SPI mode with the pin enabled.
  assign irq_out = pin_en & (level_sensitive_select ? next_irq_active
                                                    : (next_irq_active &&
                                                       pstate == sirq_pkg::SIRQ_P_IDLE));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pin <= 1'b0;
    end else if (clk_en) begin
      irq_pin <= pin_level(irq_out, interrupt_polarity);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_pin_n <= 1'b1;
    end else if (clk_en) begin
      alarm_pin_n <= ~alm_if.req_level;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_transmit_pin <= 1'b1;
    end else if (clk_en) begin
      if (pin_en && spi_mode) begin
        serial_transmit_pin <= pin_level(irq_out, interrupt_polarity);
      end else begin
        serial_transmit_pin <= uart_tx;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_irq <= 1'b0;
    end else if (clk_en) begin
      unit_irq <= |(ev_stat & ev_en);
    end
  end

  // After reset every mask bit is set and level signalling is selected.
  a_mask_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> (gen_mask == `SIRQ_MASK_RESET))
    else $error("Masks not all set after reset.");

  a_alm_mask_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> (alm_mask == `SIRQ_MASK_RESET))
    else $error("Alarm mask not all set after reset.");

  a_cfg_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> (level_sensitive_select && (cfg == `SIRQ_CFG_RESET)))
    else $error("Configuration not at its reset value after reset.");

  // Fully masked banks must stay silent on both pins.
  a_masked_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && (gen_mask == `SIRQ_MASK_RESET) && (alm_mask == `SIRQ_MASK_RESET))
      |-> !next_irq_active)
    else $error("Masked events raised a request.");

  a_alarm_masked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && (alm_mask == `SIRQ_MASK_RESET)) |=> alarm_pin_n)
    else $error("Masked alarm drove the alarm pin.");

  // In level mode the pin mirrors the pending requests one clock later.
  a_pol_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && pin_en && level_sensitive_select && next_irq_active)
      |=> (irq_pin == $past(interrupt_polarity)))
    else $error("Interrupt pin level wrong for polarity.");

  a_level_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && level_sensitive_select && pin_en && gen_if.req_level && !gen_if.read_clr
      && $stable(cfg)) |=> (irq_pin == $past(interrupt_polarity)))
    else $error("Level interrupt dropped while flag pending.");

  a_level_unmask: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && level_sensitive_select && pin_en && ((gen_if.sticky & ~gen_mask) != '0))
      |=> (irq_pin == $past(interrupt_polarity)))
    else $error("Unmasked pending flag did not raise the level interrupt.");

  a_level_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && level_sensitive_select && !next_irq_active)
      |=> (irq_pin == !$past(interrupt_polarity)))
    else $error("Level interrupt active without a pending flag.");

  a_pin_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && !pin_en) |=> (irq_pin == !$past(interrupt_polarity)))
    else $error("Interrupt pin active while the pin is disabled.");

  // In edge mode only a fresh one-shot in the idle state makes a pulse.
  sequence s_edge_fire;
    clk_en && !level_sensitive_select && pin_en && irq_out;
  endsequence
  a_edge_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_edge_fire ##1 clk_en && !level_sensitive_select
      |=> (irq_pin == !interrupt_polarity))
    else $error("Edge interrupt pulse longer than one clock.");

  sequence s_edge_new;
    clk_en && !level_sensitive_select && pin_en && (pstate == sirq_pkg::SIRQ_P_IDLE)
      && (gen_if.req_edge || alm_if.req_edge);
  endsequence
  a_edge_fires: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_edge_new |=> (irq_pin == $past(interrupt_polarity)))
    else $error("One-shot event did not raise an edge pulse.");

  sequence s_edge_idle;
    clk_en && !level_sensitive_select && !next_irq_active;
  endsequence
  a_edge_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_edge_idle |=> (irq_pin == !$past(interrupt_polarity)))
    else $error("Edge interrupt raised without a new one-shot.");

  a_alarm_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en |=> (alarm_pin_n == !$past(alm_if.req_level)))
    else $error("Alarm pin does not follow alarm request.");

  a_alarm_raise: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && alm_if.req_level) |=> !alarm_pin_n)
    else $error("Pending alarm did not pull the alarm pin low.");

  // The transmit pin carries either the routed interrupt or the serial data.
  a_tx_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && pin_en && spi_mode) |=> (serial_transmit_pin == irq_pin))
    else $error("Transmit pin does not carry the routed interrupt.");

  a_tx_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && !(pin_en && spi_mode)) |=> (serial_transmit_pin == $past(uart_tx)))
    else $error("Transmit pin does not carry the serial data.");

  a_gen_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && gen_if.read_clr) |=> (rdata == $past(gen_if.sticky)))
    else $error("General flag read returned the wrong word.");

  a_alm_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && alm_if.read_clr) |=> (rdata == $past(alm_if.sticky)))
    else $error("Alarm flag read returned the wrong word.");

  a_read_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && !rd) |=> (rdata == '0))
    else $error("Read data not zero outside a read.");

  a_event_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && general_interrupt_request) |=> ev_stat[`SIRQ_EV_GEN_BIT])
    else $error("General request did not set its event bit.");

  a_unit_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && (ev_en == 3'h0)) |=> !unit_irq)
    else $error("Unit interrupt raised with no event enabled.");
endmodule : sirq_top

//--- testbench/sirq_host_model.sv
// Host controller model: watches the interrupt pin and counts its active cycles.
module sirq_host_model (
  input wire logic sys_clk, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic irq_pin, // Interrupt pin from the unit.
  input wire logic act_high, // Active level the host expects.
  input wire logic cnt_clr, // Restarts the cycle count.
  output logic irq_act, // Interrupt seen active.
  output logic [7:0] act_cycles // Active cycles since the last restart.
);
  timeunit 1ns;
  timeprecision 1ns;
  assign irq_act = (irq_pin == act_high);
  // The count saturates so that a stuck pin cannot wrap back to a small value.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_cycles <= 8'h00;
    end else if (cnt_clr) begin
      act_cycles <= 8'h00;
    end else if (irq_act && act_cycles != 8'hFF) begin
      act_cycles <= act_cycles + 8'h01;
    end
  end
endmodule : sirq_host_model

//--- testbench/status_interrupt_request_unit_bench.sv
// Self-checking bench of the status interrupt request unit.
`include "sirq_regs.svh"
module status_interrupt_request_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] gen_cond = 16'h0000;
  logic [15:0] alm_cond = 16'h0000;
  logic uart_tx = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic clk_en = 1'b1;
  logic act_high = 1'b1;
  logic cnt_clr = 1'b0;
  logic [15:0] rdata;
  logic irq_pin, alarm_pin_n, serial_transmit_pin, unit_irq, irq_act;
  logic [7:0] act_cycles;
  logic [31:0] seed = 32'h1B8420B8;
  logic [15:0] r;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #50 sys_clk = ~sys_clk;
  sirq_top #(.W(16)) sirq_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .gen_cond(gen_cond), .alm_cond(alm_cond), .uart_tx(uart_tx), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq_pin(irq_pin),
    .alarm_pin_n(alarm_pin_n), .serial_transmit_pin(serial_transmit_pin),
    .unit_irq(unit_irq));
  sirq_host_model sirq_host_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .irq_pin(irq_pin), .act_high(act_high), .cnt_clr(cnt_clr), .irq_act(irq_act),
    .act_cycles(act_cycles));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg
  // The expected word is queued before the strobe; the monitor compares it later.
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e,
      input logic [15:0] m = 16'hFFFF);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_cyc
  task automatic pulse_test(input logic [15:0] g, input logic [15:0] e);
    @(posedge sys_clk);
    cnt_clr <= 1'b1;
    @(posedge sys_clk);
    cnt_clr <= 1'b0;
    gen_cond <= g;
    wait_cyc(6);
    check(16'(act_cycles), e);
  endtask : pulse_test
  always @(posedge sys_clk) begin
    if (rd_seen) begin
      check(rdata & msk_q.pop_front(), exp_q.pop_front());
    end
    rd_seen <= rd;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_reg(`SIRQ_OFF_GEN_MASK, 16'hFFFF);
    rd_reg(`SIRQ_OFF_ALM_MASK, 16'hFFFF);
    rd_reg(`SIRQ_OFF_CONFIG, 16'h0003);
    rd_reg(4'hF, 16'h0000);
    wait_cyc(2);
    check(16'(alarm_pin_n), 16'h0001);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr_reg(`SIRQ_OFF_GEN_MASK, 16'h0000);
    clk_en <= 1'b1;
    rd_reg(`SIRQ_OFF_GEN_MASK, 16'hFFFF);
    $display("reset test done");
    wr_reg(`SIRQ_OFF_CONFIG, 16'h0007);
    seed = lfsr(seed);
    r = seed[15:0] | 16'h0008;
    @(posedge sys_clk);
    gen_cond <= r;
    wait_cyc(3);
    check(16'(irq_pin), 16'h0000);
    @(posedge sys_clk);
    gen_cond <= 16'h0000;
    rd_reg(`SIRQ_OFF_GEN_FLAGS, r);
    rd_reg(`SIRQ_OFF_GEN_FLAGS, 16'h0000);
    $display("mask test done");
    @(posedge sys_clk);
    gen_cond <= 16'h0008;
    wr_reg(`SIRQ_OFF_GEN_MASK, 16'hFFF7);
    wait_cyc(3);
    check(16'(irq_pin), 16'h0001);
    rd_reg(`SIRQ_OFF_GEN_FLAGS, 16'h0008);
    rd_reg(`SIRQ_OFF_GEN_FLAGS, 16'h0008);
    @(posedge sys_clk);
    gen_cond <= 16'h0000;
    wait_cyc(3);
    check(16'(irq_pin), 16'h0001);
    wr_reg(`SIRQ_OFF_IRQ_EN, 16'h0001);
    wait_cyc(3);
    check(16'(unit_irq), 16'h0001);
    wr_reg(`SIRQ_OFF_IRQ_EN, 16'h0000);
    wait_cyc(3);
    check(16'(unit_irq), 16'h0000);
    wr_reg(`SIRQ_OFF_IRQ_EN, 16'h0001);
    wr_reg(`SIRQ_OFF_IRQ_CLR, 16'h0001);
    wait_cyc(3);
    check(16'(unit_irq), 16'h0001);
    rd_reg(`SIRQ_OFF_IRQ_STAT, 16'h0001, 16'h0001);
    rd_reg(`SIRQ_OFF_GEN_FLAGS, 16'h0008);
    wait_cyc(3);
    check(16'(irq_pin), 16'h0000);
    wr_reg(`SIRQ_OFF_IRQ_CLR, 16'h0001);
    wait_cyc(3);
    check(16'(unit_irq), 16'h0000);
    $display("level test done");
    wr_reg(`SIRQ_OFF_ALM_MASK, 16'hFFFE);
    wr_reg(`SIRQ_OFF_CONFIG, 16'h0005);
    act_high <= 1'b0;
    wait_cyc(3);
    check(16'(irq_pin), 16'h0001);
    @(posedge sys_clk);
    alm_cond <= 16'h0001;
    wait_cyc(3);
    check(16'(irq_act), 16'h0001);
    check(16'(alarm_pin_n), 16'h0000);
    @(posedge sys_clk);
    alm_cond <= 16'h0000;
    rd_reg(`SIRQ_OFF_ALM_FLAGS, 16'h0001);
    wait_cyc(3);
    check(16'(irq_pin), 16'h0001);
    check(16'(alarm_pin_n), 16'h0001);
    $display("alarm test done");
    wr_reg(`SIRQ_OFF_CONFIG, 16'h0006);
    act_high <= 1'b1;
    pulse_test(16'h0010, 16'h0000);
    wr_reg(`SIRQ_OFF_GEN_MASK, 16'hFFE7);
    pulse_test(16'h0010, 16'h0000);
    pulse_test(16'h0018, 16'h0001);
    pulse_test(16'h0000, 16'h0000);
    pulse_test(16'h0010, 16'h0001);
    $display("edge test done");
    wr_reg(`SIRQ_OFF_CONFIG, 16'h0007);
    repeat (4) begin
      seed = lfsr(seed);
      @(posedge sys_clk);
      uart_tx <= seed[0];
      wait_cyc(2);
      check(16'(serial_transmit_pin), 16'(seed[0]));
    end
    @(posedge sys_clk);
    uart_tx <= 1'b0;
    wr_reg(`SIRQ_OFF_CONFIG, 16'h000F);
    wait_cyc(3);
    check(16'(serial_transmit_pin), 16'h0001);
    rd_reg(`SIRQ_OFF_LIVE, 16'h0001);
    wr_reg(`SIRQ_OFF_CONFIG, 16'h0001);
    wait_cyc(3);
    check(16'(irq_pin), 16'h0001);
    check(16'(serial_transmit_pin), 16'h0000);
    $display("pin routing test done");
    wait_cyc(3);
    tally_and_finish();
  end
endmodule : status_interrupt_request_unit_bench
